// ==== rtl/pmt_pkg.sv ====
package pmt_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned ADC_HOLD_MS       = 1;
  localparam int unsigned INT_MIN_NORMAL_US = 10;
  localparam int unsigned INT_MIN_FAST_US   = 1;
  localparam int unsigned SETTLE_CYCLES     = 8;

  // Minimum times round up to whole cycles; the hold time is a longest time.
  localparam int unsigned ADC_HOLD_CYCLES =
    (ADC_HOLD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned INT_MIN_NORMAL_CYCLES =
    (INT_MIN_NORMAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INT_MIN_FAST_CYCLES =
    (INT_MIN_FAST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Band selection
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BAND_ZERO = 3'h0;

  // ---------------------------------------------------------------------------
  // Integrator gate states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMT_INT_OPEN   = 2'b00,
    PMT_INT_SETTLE = 2'b01,
    PMT_INT_CLOSED = 2'b10
  } pmt_int_state_t;

endpackage

// ==== rtl/pmt_pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------------------
// Three-stage pin synchroniser; the level changes once stages two and three
// agree.
// -----------------------------------------------------------------------------
module pmt_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic [2:0] stage_reg;
  logic       level_reg;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_reg <= {3{RESET_LEVEL}};
    end else begin
      stage_reg <= {stage_reg[1:0], pin_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_reg <= RESET_LEVEL;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_reg <= stage_reg[2];
    end
  end

  assign level_o = level_reg;

endmodule

`default_nettype wire

// ==== rtl/pmt_timing_gen.sv ====
`timescale 1ns/1ns
`default_nettype none

module pmt_timing_gen #(
  parameter int unsigned ADC_HOLD_CYCLES   = pmt_pkg::ADC_HOLD_CYCLES,
  parameter int unsigned INT_MIN_NORMAL    = pmt_pkg::INT_MIN_NORMAL_CYCLES,
  parameter int unsigned INT_MIN_FAST      = pmt_pkg::INT_MIN_FAST_CYCLES,
  parameter int unsigned SETTLE_CYCLES     = pmt_pkg::SETTLE_CYCLES
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       pulse_in_i,
  input  wire logic       pulse_in_driven_i,
  input  wire logic [2:0] band_sel_i,
  input  wire logic       fast_mode_i,
  output logic            rf_on_o,
  output logic            mod_drive_band0_o,
  output logic            mod_drive_band14_o,
  output logic            sample_o,
  output logic            adc_enable_o,
  output logic            integrate_o
);

  // Every counter shares one width. Twenty bits hold the default hold time
  // of the ADC enable with room to spare; a longer hold needs a wider CW.
  localparam int unsigned CW = 20;

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  // Refuse timings that the counters cannot hold or that make no sense.
  if (ADC_HOLD_CYCLES < 1 || ADC_HOLD_CYCLES >= (1 << CW) ||
      INT_MIN_NORMAL < 1 || INT_MIN_NORMAL >= (1 << CW) ||
      INT_MIN_FAST < 1 || INT_MIN_FAST > INT_MIN_NORMAL ||
      SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CW)) begin : g_bad
    $error("pmt_timing_gen: timing parameter out of range");
  end

  localparam logic [CW-1:0] ADC_LOAD  = CW'(ADC_HOLD_CYCLES);
  localparam logic [CW-1:0] NORM_LOAD = CW'(INT_MIN_NORMAL);
  localparam logic [CW-1:0] FAST_LOAD = CW'(INT_MIN_FAST);
  localparam logic [CW-1:0] SET_LOAD  = CW'(SETTLE_CYCLES);

  // ---------------------------------------------------------------------------
  // Pulse input
  // ---------------------------------------------------------------------------
  // The pin is asynchronous to the clock, so it passes the three-stage
  // synchroniser before anything else looks at it. The filter costs five
  // cycles of latency from pin to outputs, which is negligible against the
  // microsecond timing that the leveling gates need.
  logic pin_level;
  logic rf_on;
  logic rf_on_d_reg;
  logic rf_rise;
  logic rf_fall;

  // The internal pull-up level stands in for a floating input.
  pmt_pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (pulse_in_i | ~pulse_in_driven_i),
    .level_o   (pin_level)
  );

  assign rf_on = pin_level;

  // The delayed copy resets high, like the synchroniser, so that leaving
  // reset with the pin low shows one clean fall and no false rise.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rf_on_d_reg <= 1'b1;
    end else begin
      rf_on_d_reg <= rf_on;
    end
  end

  assign rf_rise = rf_on & ~rf_on_d_reg;
  assign rf_fall = ~rf_on & rf_on_d_reg;

  // ---------------------------------------------------------------------------
  // Modulator drive and sample/hold
  // ---------------------------------------------------------------------------
  // The drives are registered from the same level as the RF state, so the
  // modulator current and the RF flag always change on the same edge. A band
  // change between zero and any other band while RF is off moves the drive to the other modulator on the next clock edge.
  logic rf_on_reg;
  logic drv0_reg;
  logic drv14_reg;
  logic sample_reg;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rf_on_reg  <= 1'b1;
      drv0_reg   <= 1'b0;
      drv14_reg  <= 1'b0;
      sample_reg <= 1'b1;
    end else begin
      rf_on_reg  <= rf_on;
      // Never both high by construction: RF on clears both, else the band decides which side gets it.
      drv0_reg   <= ~rf_on & (band_sel_i == pmt_pkg::BAND_ZERO);
      drv14_reg  <= ~rf_on & (band_sel_i != pmt_pkg::BAND_ZERO);
      sample_reg <= rf_on;
    end
  end

  // ---------------------------------------------------------------------------
  // ADC enable
  // ---------------------------------------------------------------------------
  // The enable stays up while RF is on and for the hold time after RF goes
  // off. Past that the held sample has drooped and must not be converted. A
  // new RF-on pulse inside the hold time simply restarts the whole cycle.
  logic [CW-1:0] adc_cnt_reg;
  logic          adc_en_reg;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_cnt_reg <= '0;
      adc_en_reg  <= 1'b1;
    end else if (rf_on) begin
      adc_cnt_reg <= '0;
      adc_en_reg  <= 1'b1;
    end else if (rf_fall) begin
      adc_cnt_reg <= ADC_LOAD - CW'(1);
      adc_en_reg  <= 1'b1;
    end else if (adc_cnt_reg != '0) begin
      adc_cnt_reg <= adc_cnt_reg - CW'(1);
    end else begin
      adc_en_reg  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Integrator gate
  // ---------------------------------------------------------------------------
  // The minimum closure is latched at closure so a mode change mid-pulse
  // cannot cut a closure short.
  // Settling starts on each RF rise; a fall during settling abandons it, so
  // a pulse shorter than the settling time never closes the gate. Once
  // closed, the gate ignores RF until the minimum closure has run out, which
  // speeds the loop's response to narrow pulses.
  // Only the state left by reset starts settling without a rise, because RF
  // is taken to be on when the block comes out of reset.
  pmt_pkg::pmt_int_state_t st_reg;
  logic [CW-1:0]           set_cnt_reg;
  logic [CW-1:0]           min_cnt_reg;
  logic                    int_reg;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg      <= pmt_pkg::PMT_INT_OPEN;
      set_cnt_reg <= '0;
      min_cnt_reg <= '0;
      int_reg     <= 1'b0;
    end else begin
      case (st_reg)
        pmt_pkg::PMT_INT_OPEN: begin
          int_reg <= 1'b0;
          if (rf_rise || (rf_on && !int_reg && set_cnt_reg == '0)) begin
            st_reg      <= pmt_pkg::PMT_INT_SETTLE;
            set_cnt_reg <= SET_LOAD - CW'(1);
          end
        end
        pmt_pkg::PMT_INT_SETTLE: begin
          if (!rf_on) begin
            st_reg      <= pmt_pkg::PMT_INT_OPEN;
            set_cnt_reg <= CW'(1);
          end else if (set_cnt_reg != '0) begin
            set_cnt_reg <= set_cnt_reg - CW'(1);
          end else begin
            st_reg      <= pmt_pkg::PMT_INT_CLOSED;
            int_reg     <= 1'b1;
            min_cnt_reg <= (fast_mode_i ? FAST_LOAD : NORM_LOAD)
                           - CW'(1);
          end
        end
        pmt_pkg::PMT_INT_CLOSED: begin
          if (min_cnt_reg != '0) begin
            min_cnt_reg <= min_cnt_reg - CW'(1);
          end else if (!rf_on) begin
            st_reg      <= pmt_pkg::PMT_INT_OPEN;
            int_reg     <= 1'b0;
            set_cnt_reg <= CW'(1);
          end
        end
        default: begin
          st_reg  <= pmt_pkg::PMT_INT_OPEN;
          int_reg <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Every output comes straight from a flip-flop; nothing here is decoded,
  // so the gates downstream never see a combinational glitch.
  assign rf_on_o            = rf_on_reg;
  assign mod_drive_band0_o  = drv0_reg;
  assign mod_drive_band14_o = drv14_reg;
  assign sample_o           = sample_reg;
  assign adc_enable_o       = adc_en_reg;
  assign integrate_o        = int_reg;

endmodule

`default_nettype wire

// ==== test/pmt_pulse_src.sv ====
`timescale 1ns/1ns
`default_nettype none
// Pulse source at the front-panel pin. A released pin toggles every cycle,
// so a design that reads it instead of the pull-up level shows up at once.
module pmt_pulse_src (
  input  wire logic sys_clk_i,
  input  wire logic level_i,
  input  wire logic drive_i,
  output logic      pin_o,
  output logic      driven_o
);
  logic junk_reg = 1'b0;
  always @(posedge sys_clk_i) junk_reg <= ~junk_reg;
  assign pin_o    = drive_i ? level_i : junk_reg;
  assign driven_o = drive_i;
endmodule
`default_nettype wire

// ==== test/pmt_timing_gen_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmt_timing_gen_chk #(
  parameter int unsigned ADC_HOLD_CYCLES = 20,
  parameter int unsigned INT_MIN_NORMAL  = 10,
  parameter int unsigned INT_MIN_FAST    = 3,
  parameter int unsigned SETTLE_CYCLES   = 2
) (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       pulse_in_i,
  input wire logic       pulse_in_driven_i,
  input wire logic [2:0] band_sel_i,
  input wire logic       fast_mode_i,
  input wire logic       rf_on_o,
  input wire logic       mod_drive_band0_o,
  input wire logic       mod_drive_band14_o,
  input wire logic       sample_o,
  input wire logic       adc_enable_o,
  input wire logic       integrate_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [19:0] off_reg;
  logic [19:0] on_reg;
  logic [19:0] cl_reg;
  logic [19:0] min_reg;
  // The closure minimum is latched while the gate is open, as the mode only
  // counts at the moment of closure.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      off_reg <= '0;
      on_reg  <= 20'(SETTLE_CYCLES + 1);
      cl_reg  <= '0;
      min_reg <= 20'(INT_MIN_NORMAL);
    end else begin
      off_reg <= rf_on_o ? '0 : off_reg + 20'(off_reg < ADC_HOLD_CYCLES);
      on_reg  <= !rf_on_o ? '0 : on_reg + 20'(on_reg <= SETTLE_CYCLES);
      cl_reg  <= integrate_o ? cl_reg + 20'h1 : '0;
      if (!integrate_o) begin
        min_reg <= 20'(fast_mode_i ? INT_MIN_FAST : INT_MIN_NORMAL);
      end
    end
  end
  sequence s_pin_low;
    (pulse_in_driven_i && !pulse_in_i) [*6];
  endsequence
  sequence s_pin_high;
    (pulse_in_i || !pulse_in_driven_i) [*6];
  endsequence
  sequence s_settled;
    rf_on_o && on_reg == SETTLE_CYCLES ##1 rf_on_o;
  endsequence
  a_rf_off_low: assert property (s_pin_low |-> !rf_on_o)
    else $error("rf on while pin held low");
  a_rf_on_high: assert property (s_pin_high |-> rf_on_o)
    else $error("rf off while pin high or released");
  a_sample_rf: assert property (sample_o == rf_on_o)
    else $error("sample gate differs from rf state");
  a_drive_idle: assert property (rf_on_o |->
    !mod_drive_band0_o && !mod_drive_band14_o) else $error("drive while rf on");
  a_drive_route: assert property (
    !rf_on_o && $stable(band_sel_i) |->
    mod_drive_band0_o == (band_sel_i == 3'h0) &&
    mod_drive_band14_o == (band_sel_i != 3'h0)) else $error("bad drive route");
  a_adc_hold_time: assert property (adc_enable_o ==
    (rf_on_o || off_reg < ADC_HOLD_CYCLES)) else $error("adc enable timing");
  a_int_closes: assert property (
    s_settled |-> $past(integrate_o))
    else $error("integrator not closed after settling");
  a_int_early: assert property ($rose(integrate_o) |->
    rf_on_o && on_reg >= SETTLE_CYCLES) else $error("integrator closed early");
  a_int_min_time: assert property ($fell(integrate_o) |->
    cl_reg >= min_reg) else $error("integrator closure too short");
  a_int_opens: assert property (off_reg >= 20'h3 &&
    cl_reg > min_reg + 20'h3 |-> !integrate_o) else $error("integrator stuck");
endmodule
bind pmt_timing_gen pmt_timing_gen_chk #(
  .ADC_HOLD_CYCLES(ADC_HOLD_CYCLES), .INT_MIN_NORMAL(INT_MIN_NORMAL),
  .INT_MIN_FAST(INT_MIN_FAST), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .pulse_in_i(pulse_in_i),
  .pulse_in_driven_i(pulse_in_driven_i), .band_sel_i(band_sel_i),
  .fast_mode_i(fast_mode_i), .rf_on_o(rf_on_o), .sample_o(sample_o),
  .mod_drive_band0_o(mod_drive_band0_o), .integrate_o(integrate_o),
  .mod_drive_band14_o(mod_drive_band14_o), .adc_enable_o(adc_enable_o)
);
`default_nettype wire

// ==== test/pmt_timing_gen_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmt_timing_gen_tb;
  localparam int H = 20;
  localparam int NM = 10;
  localparam int FM = 3;
  localparam int ST = 2;
  logic       sys_clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       lvl = 1'b1;
  logic       drv = 1'b1;
  logic       fast = 1'b0;
  logic [2:0] band = 3'h0;
  logic       pin, pin_drv, rf, d0, d14, smp, adc, integ;
  logic       s1, s2, s3, lv, erf, e0, e14, seen_low;
  int         ac, on_c, ic, min_e;
  int         failures = 0;
  int         n_tests = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  pmt_pulse_src SRC (.sys_clk_i(sys_clk_i), .level_i(lvl), .drive_i(drv),
    .pin_o(pin), .driven_o(pin_drv));
  pmt_timing_gen #(.ADC_HOLD_CYCLES(H), .INT_MIN_NORMAL(NM),
    .INT_MIN_FAST(FM), .SETTLE_CYCLES(ST)) DUT (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .pulse_in_i(pin), .pulse_in_driven_i(pin_drv),
    .band_sel_i(band), .fast_mode_i(fast), .rf_on_o(rf),
    .mod_drive_band0_o(d0), .mod_drive_band14_o(d14), .sample_o(smp),
    .adc_enable_o(adc), .integrate_o(integ));
  task automatic check(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: output differs from model", $time);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Model: three-stage pin filter, then one registered stage to the outputs.
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {s1, s2, s3, lv, erf, e0, e14} = 7'h7C;
      ac = 0;
    end else begin
      ac = erf ? 0 : (ac < H ? ac + 1 : H);
      erf = lv;
      e0 = !lv && band == 3'h0;
      e14 = !lv && band != 3'h0;
      if (s2 == s3) lv = s3;
      s3 = s2;
      s2 = s1;
      s1 = pin | ~pin_drv;
    end
  end
  always @(negedge sys_clk_i) begin
    check(rf, erf);
    check(smp, erf);
    check(adc, erf || ac < H);
    check(d0, e0);
    check(d14, e14);
    if (integ && ic == 0 && seen_low)
      check(on_c >= ST && on_c <= ST + 1, 1'b1);
    // A reset may cut a closure short; that is not a timing fault.
    if (rstn_i && !integ && ic > 0) check(ic >= min_e, 1'b1);
    check(!(integ && ac > 3 && ic > min_e + 3), 1'b1);
    on_c = rf ? on_c + 1 : 0;
    ic = integ ? ic + 1 : 0;
    seen_low = rstn_i && (seen_low || !rf);
    if (!integ) min_e = fast ? FM : NM;
  end
  initial begin
    int i;
    void'($urandom(32'h8F0610A5));
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 90; i++) begin
      @(posedge sys_clk_i);
      lvl <= 1'($urandom);
      drv <= ($urandom % 4) != 0;
      band <= 3'($urandom % 5);
      fast <= 1'($urandom);
      if (i == 45) rstn_i <= 1'b0;
      repeat ($urandom_range(1, 30)) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
    end
    repeat (40) @(posedge sys_clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
